// file: core/csds_core.sv
// Purpose: decode bus address into stack drive, sink, return and source enables
// Assumes: bus pins are asynchronous and pass two flip-flops first
// Notes: one memory cycle is a read half then a write half, 300 ns each
//
// What this block does
// - power fail low blocks address match
// - power fail low turns all returns off
// - bus reset low resets control logic
// - bits 1-3 pick group c read, a write
// - bits 4-6 pick group a read, c write
// - bits 10-13 pick one x sink
// - bits 7,8,9,14 pick one y sink
// - sink plus drive picks one line
// - read returns in read, write returns in write
// - return enables last one 300 ns pulse; source enables span both halves
// - two sources, each its own enable
// - read pulse 300 ns, then write or end

`timescale 1ns/1ps

// ****************************************
// one-hot decoder, reused for drive and sink
// ****************************************
module csds_decoder #(
  parameter int IN_W = 3
) (
  input wire logic [IN_W-1:0] code_in,
  input wire logic enable_in,
  output logic [(1<<IN_W)-1:0] onehot_out
);
  // exactly one bit high while enabled, none otherwise
  always_comb begin
    onehot_out = '0;
    if (enable_in) begin
      onehot_out[code_in] = 1'b1;
    end
  end
endmodule

`timescale 1ns/1ps

module csds_core
  import csds_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic power_fail_low_in,
  input wire logic bus_reset_low_in,
  input wire logic master_sync_in,
  input wire logic read_pause_in,
  input wire logic [CSDS_BLK_W-1:0] block_strap_in,
  input wire logic [CSDS_ADDR_W-1:0] address_in,
  output logic address_match_out,
  output logic busy_out,
  output logic read_timing_pulse_out,
  output logic write_timing_pulse_out,
  output logic [7:0] drive_group_a_out,
  output logic [7:0] drive_group_c_out,
  output logic [15:0] x_sink_select_out,
  output logic [15:0] y_sink_select_out,
  output logic x_read_return_out,
  output logic y_read_return_out,
  output logic x_write_return_out,
  output logic y_write_return_out,
  output logic source_one_enable_out,
  output logic source_two_enable_out
);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic pf_meta_q;                           // power fail, first stage
  logic pf_ok_q;                             // power good, high = supplies fine
  logic rst_meta_q;                          // bus reset, first stage
  logic rst_low_q;                           // bus reset level, active low
  logic sync_meta_q;                         // master sync, first stage
  logic sync_q;                              // master sync, settled
  logic sync_old_q;                          // previous settled sync, for edge
  logic pause_meta_q;                        // read pause request, first stage
  logic pause_req_q;                         // read pause request, settled
  logic [CSDS_BLK_W-1:0] strap_meta_q;       // block strap, first stage
  logic [CSDS_BLK_W-1:0] strap_q;            // block strap, settled
  logic [CSDS_ADDR_W-1:0] addr_meta_q;       // address, first stage
  logic [CSDS_ADDR_W-1:0] addr_sync_q;       // address, settled

  // supplies are assumed bad at reset so nothing starts too early
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pf_meta_q <= 1'b0;
      pf_ok_q <= 1'b0;
      rst_meta_q <= 1'b0;
      rst_low_q <= 1'b0;
      sync_meta_q <= 1'b0;
      sync_q <= 1'b0;
      sync_old_q <= 1'b0;
      pause_meta_q <= 1'b0;
      pause_req_q <= 1'b0;
      strap_meta_q <= '0;
      strap_q <= '0;
      addr_meta_q <= '0;
      addr_sync_q <= '0;
    end else if (clk_en_in) begin
      pf_meta_q <= power_fail_low_in;
      pf_ok_q <= pf_meta_q;
      rst_meta_q <= bus_reset_low_in;
      rst_low_q <= rst_meta_q;
      sync_meta_q <= master_sync_in;
      sync_q <= sync_meta_q;
      sync_old_q <= sync_q;
      pause_meta_q <= read_pause_in;
      pause_req_q <= pause_meta_q;
      strap_meta_q <= block_strap_in;
      strap_q <= strap_meta_q;
      addr_meta_q <= address_in;
      addr_sync_q <= addr_meta_q;
    end
  end

  // ****************************************
  // address match and cycle start
  // ****************************************
  logic match_d;                             // block selected and power good
  logic start_d;                             // new cycle accepted this edge

  assign match_d = pf_ok_q &&
                   (addr_sync_q[CSDS_BLK_LSB +: CSDS_BLK_W] == strap_q);

  // ****************************************
  // half-cycle sequencer
  // ****************************************
  csds_state_type state_q;                   // current half cycle
  logic [3:0] cnt_q;                         // cycles spent in this half
  logic pause_q;                             // next cycle skips its read half
  logic cycle_pause_q;                       // current cycle is a read pause
  logic [CSDS_ADDR_W-1:0] addr_q;            // address held for the cycle
  logic half_end;                            // last cycle of a half

  // only a rising master sync in idle starts a cycle
  assign start_d = match_d && sync_q && !sync_old_q && (state_q == CSDS_IDLE);
  assign half_end = (cnt_q == CSDS_HALF_CYC - 4'h1);

  // state walk; bus reset acts as a synchronous clear of the control
  // bus reset low clears sequence
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= CSDS_IDLE;
      cnt_q <= 4'h0;
    end else if (clk_en_in) begin
      if (!rst_low_q) begin
        state_q <= CSDS_IDLE;
        cnt_q <= 4'h0;
      end else begin
        case (state_q)
          CSDS_IDLE: begin
            cnt_q <= 4'h0;
            // after a read pause the cycle opens with the write half
            if (start_d) begin
              state_q <= pause_q ? CSDS_WRITE : CSDS_READ;
            end
          end
          CSDS_READ: begin
            cnt_q <= cnt_q + 4'h1;
            if (half_end) begin
              cnt_q <= 4'h0;
              // a read pause ends after its read half, no restore
              state_q <= cycle_pause_q ? CSDS_DONE : CSDS_WRITE;
            end
          end
          CSDS_WRITE: begin
            cnt_q <= cnt_q + 4'h1;
            if (half_end) begin
              cnt_q <= 4'h0;
              state_q <= CSDS_DONE;
            end
          end
          CSDS_DONE: begin
            cnt_q <= 4'h0;
            state_q <= CSDS_IDLE;
          end
          default: begin
            cnt_q <= 4'h0;
            state_q <= CSDS_IDLE;
          end
        endcase
      end
    end
  end

  // address latch and pause bookkeeping, taken when a cycle starts and when it reaches done
  // pause picks the next start
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_q <= '0;
      pause_q <= 1'b0;
      cycle_pause_q <= 1'b0;
    end else if (clk_en_in) begin
      if (!rst_low_q) begin
        pause_q <= 1'b0;
        cycle_pause_q <= 1'b0;
      end else if (start_d) begin
        addr_q <= addr_sync_q;
        // a pause cycle is never itself the follower of a pause
        cycle_pause_q <= pause_req_q && !pause_q;
      end else if (state_q == CSDS_DONE) begin
        pause_q <= cycle_pause_q;
        cycle_pause_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // drive and sink decode
  // ****************************************
  logic in_read;                             // read half active
  logic in_write;                            // write half active
  logic [CSDS_DRV_W-1:0] code_a;             // code for group a
  logic [CSDS_DRV_W-1:0] code_c;             // code for group c
  logic [CSDS_SINK_W-1:0] code_xs;           // x sink code
  logic [CSDS_SINK_W-1:0] code_ys;           // y sink code
  logic [7:0] dec_a;
  logic [7:0] dec_c;
  logic [15:0] dec_xs;
  logic [15:0] dec_ys;
  logic half_on;                             // any half cycle active

  assign in_read = (state_q == CSDS_READ);
  assign in_write = (state_q == CSDS_WRITE);
  assign half_on = in_read || in_write;

  // low bits to c in read, a in write
  // high bits to a in read, c in write
  assign code_c = in_read ? addr_q[CSDS_LOW_LSB +: CSDS_DRV_W]
                          : addr_q[CSDS_HIGH_LSB +: CSDS_DRV_W];
  assign code_a = in_read ? addr_q[CSDS_HIGH_LSB +: CSDS_DRV_W]
                          : addr_q[CSDS_LOW_LSB +: CSDS_DRV_W];
  assign code_xs = addr_q[CSDS_XS_LSB +: CSDS_SINK_W];
  // y sink from bits 7,8,9 and 14
  assign code_ys = {addr_q[CSDS_YS_TOP], addr_q[CSDS_YS_LSB +: CSDS_SINK_W - 1]};

  // one drive per axis with one sink
  csds_decoder #(.IN_W(CSDS_DRV_W)) u_dec_a (
    .code_in(code_a),
    .enable_in(half_on),
    .onehot_out(dec_a)
  );
  csds_decoder #(.IN_W(CSDS_DRV_W)) u_dec_c (
    .code_in(code_c),
    .enable_in(half_on),
    .onehot_out(dec_c)
  );
  csds_decoder #(.IN_W(CSDS_SINK_W)) u_dec_xs (
    .code_in(code_xs),
    .enable_in(half_on),
    .onehot_out(dec_xs)
  );
  csds_decoder #(.IN_W(CSDS_SINK_W)) u_dec_ys (
    .code_in(code_ys),
    .enable_in(half_on),
    .onehot_out(dec_ys)
  );

  // ****************************************
  // output registers
  // ****************************************
  csds_drive_type drive_d;                   // next stack drive pattern
  csds_drive_type drive_q;                   // registered stack drive pattern
  logic match_q;
  logic busy_q;
  logic rth_q;                               // read timing pulse
  logic wth_q;                               // write timing pulse

  // returns and sources follow the half; power fail kills every return
  always_comb begin
    drive_d = CSDS_DRIVE_OFF;
    if (half_on) begin
      drive_d.drive_group_a = dec_a;
      drive_d.drive_group_c = dec_c;
      drive_d.x_sink_select = dec_xs;
      drive_d.y_sink_select = dec_ys;
      drive_d.x_read_return = in_read;
      drive_d.y_read_return = in_read;
      drive_d.x_write_return = in_write;
      drive_d.y_write_return = in_write;
      drive_d.source_one_enable = 1'b1;
      drive_d.source_two_enable = 1'b1;
    end
    if (!pf_ok_q) begin
      drive_d.x_read_return = 1'b0;
      drive_d.y_read_return = 1'b0;
      drive_d.x_write_return = 1'b0;
      drive_d.y_write_return = 1'b0;
    end
  end

  // one register stage keeps every output glitch free;
  // each return stands exactly the half length, one cycle behind state; source enables stay on through both halves
  // return enables last one half pulse
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_q <= CSDS_DRIVE_OFF;
      match_q <= 1'b0;
      busy_q <= 1'b0;
      rth_q <= 1'b0;
      wth_q <= 1'b0;
    end else if (clk_en_in) begin
      drive_q <= rst_low_q ? drive_d : CSDS_DRIVE_OFF;
      match_q <= match_d;
      busy_q <= rst_low_q && (state_q != CSDS_IDLE);
      rth_q <= rst_low_q && in_read;
      wth_q <= rst_low_q && in_write;
    end
  end

  assign address_match_out = match_q;
  assign busy_out = busy_q;
  assign read_timing_pulse_out = rth_q;
  assign write_timing_pulse_out = wth_q;
  assign drive_group_a_out = drive_q.drive_group_a;
  assign drive_group_c_out = drive_q.drive_group_c;
  assign x_sink_select_out = drive_q.x_sink_select;
  assign y_sink_select_out = drive_q.y_sink_select;
  assign x_read_return_out = drive_q.x_read_return;
  assign y_read_return_out = drive_q.y_read_return;
  assign x_write_return_out = drive_q.x_write_return;
  assign y_write_return_out = drive_q.y_write_return;
  assign source_one_enable_out = drive_q.source_one_enable;
  assign source_two_enable_out = drive_q.source_two_enable;

endmodule

// file: include/csds_pkg.sv
// Purpose: shared constants and types for the core stack drive select
// Assumes: 10 MHz system clock, word address bits 1..17 on the bus
// Notes: all address bit positions and pulse timing live here

package csds_pkg;

  // ****************************************
  // clock and half-cycle timing
  // ****************************************
  localparam int CSDS_CLK_NS = 100;          // clock period in ns
  localparam int CSDS_HALF_NS = 300;         // half-current pulse width in ns
  // longest pulse rounds down, never below one cycle
  localparam int CSDS_HALF_CYC_I = (CSDS_HALF_NS / CSDS_CLK_NS) < 1 ? 1 :
                                   (CSDS_HALF_NS / CSDS_CLK_NS);
  localparam logic [3:0] CSDS_HALF_CYC = 4'(CSDS_HALF_CYC_I);

  // ****************************************
  // address field layout
  // ****************************************
  localparam int CSDS_ADDR_W = 18;           // bus address width
  localparam int CSDS_LOW_LSB = 1;           // drive code, bits 1..3
  localparam int CSDS_HIGH_LSB = 4;          // drive code, bits 4..6
  localparam int CSDS_XS_LSB = 10;           // x sink code, bits 10..13
  localparam int CSDS_YS_LSB = 7;            // y sink code, bits 7..9
  localparam int CSDS_YS_TOP = 14;           // y sink code, bit 14
  localparam int CSDS_BLK_LSB = 15;          // block strap compare, 15..17
  localparam int CSDS_BLK_W = 3;
  localparam int CSDS_DRV_W = 3;             // one of eight drive switches
  localparam int CSDS_SINK_W = 4;            // one of sixteen sinks

  // ****************************************
  // types
  // ****************************************
  // half-cycle sequence, gray coded along idle-read-write-done
  typedef enum logic [1:0] {
    CSDS_IDLE  = 2'h0,
    CSDS_READ  = 2'h1,
    CSDS_WRITE = 2'h3,
    CSDS_DONE  = 2'h2
  } csds_state_type;

  // everything that goes out to the analog stack circuits
  typedef struct packed {
    logic [7:0] drive_group_a;
    logic [7:0] drive_group_c;
    logic [15:0] x_sink_select;
    logic [15:0] y_sink_select;
    logic x_read_return;
    logic y_read_return;
    logic x_write_return;
    logic y_write_return;
    logic source_one_enable;
    logic source_two_enable;
  } csds_drive_type;

  localparam csds_drive_type CSDS_DRIVE_OFF = '0;

endpackage

// file: testbench/csds_core_assertions.sv
// Purpose: concurrent checks on the drive select core ports
// Assumes: clock enable held high, so bus pins settle in 2 edges
// Notes: pin-level waits cover two sync edges, the output register and one sample

`timescale 1ns/1ps

module csds_core_assertions (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic power_fail_low_in,
  input wire logic bus_reset_low_in,
  input wire logic address_match_out,
  input wire logic busy_out,
  input wire logic read_timing_pulse_out,
  input wire logic write_timing_pulse_out,
  input wire logic [7:0] drive_group_a_out,
  input wire logic [7:0] drive_group_c_out,
  input wire logic [15:0] x_sink_select_out,
  input wire logic [15:0] y_sink_select_out,
  input wire logic x_read_return_out,
  input wire logic y_read_return_out,
  input wire logic x_write_return_out,
  input wire logic y_write_return_out,
  input wire logic source_one_enable_out,
  input wire logic source_two_enable_out
);
  // ****************************************
  // helpers and properties
  // ****************************************
  logic rd, wr, any_ret;
  assign rd = read_timing_pulse_out;
  assign wr = write_timing_pulse_out;
  assign any_ret = x_read_return_out | y_read_return_out | x_write_return_out | y_write_return_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_pf_no_match: assert property (
    !power_fail_low_in [*5] |-> !address_match_out) else $error("match while power bad");
  a_pf_no_return: assert property (
    !power_fail_low_in [*5] |-> !any_ret) else $error("return on while power bad");
  a_init_idle: assert property (
    !bus_reset_low_in [*4] |-> !(busy_out | rd | wr)) else $error("active during bus reset");
  a_read_ret_half: assert property (
    (x_read_return_out | y_read_return_out) |-> rd && !wr) else $error("read return outside read");
  a_write_ret_half: assert property (
    (x_write_return_out | y_write_return_out) |-> wr && !rd) else $error("write return misplaced");
  a_idle_quiet: assert property (
    !(rd | wr) |-> {drive_group_a_out, drive_group_c_out, x_sink_select_out, y_sink_select_out,
      any_ret, source_one_enable_out, source_two_enable_out} == '0) else $error("enable when idle");
  a_sel_onehot: assert property (
    (rd | wr) |-> $onehot(drive_group_a_out) && $onehot(drive_group_c_out) &&
      $onehot(x_sink_select_out) && $onehot(y_sink_select_out) &&
      source_one_enable_out && source_two_enable_out) else $error("bad selection in half");
  a_read_width: assert property (
    $rose(rd) |-> rd [*3] ##1 !rd) else $error("read pulse not 3 cycles");
  a_write_width: assert property (
    $rose(wr) |-> wr [*3] ##1 !wr) else $error("write pulse not 3 cycles");
  a_group_swap: assert property (
    $fell(rd) && wr |-> drive_group_a_out == $past(drive_group_c_out) &&
      drive_group_c_out == $past(drive_group_a_out)) else $error("groups not swapped");

  // main scenarios reached
  c_full_cycle: cover property ($fell(rd) && wr);
  c_pause_read: cover property ($fell(rd) && !wr);
  c_write_only: cover property ($rose(wr) && !$past(rd));
endmodule

bind csds_core csds_core_assertions csds_core_assertions_i (.*);

// file: testbench/csds_stack_model.sv
// Purpose: stand-in for the analog stack, reports which lines carry current
// Assumes: a write return marks the write half, else the read half
// Notes: line index is sink code above drive code, as the wiring maps it

`timescale 1ns/1ps

module csds_stack_model
  import csds_pkg::*;
(
  input wire csds_drive_type drive_in,
  output logic [6:0] x_line_out,
  output logic [6:0] y_line_out,
  output logic sel_ok_out
);
  // ****************************************
  // line resolution
  // ****************************************
  // position of the highest set bit; a broken one-hot shows in sel_ok_out
  function automatic logic [3:0] idx(input logic [15:0] v);
    idx = '0;
    for (int i = 0; i < 16; i++) if (v[i]) idx = 4'(i);
  endfunction
  logic wh;
  assign wh = drive_in.x_write_return;
  // x uses group c in read, group a in write; y the other way round
  assign x_line_out = {idx(drive_in.x_sink_select), 3'(idx({8'h00,
    wh ? drive_in.drive_group_a : drive_in.drive_group_c}))};
  assign y_line_out = {idx(drive_in.y_sink_select), 3'(idx({8'h00,
    wh ? drive_in.drive_group_c : drive_in.drive_group_a}))};
  assign sel_ok_out = $onehot(drive_in.drive_group_a) && $onehot(drive_in.drive_group_c) &&
    $onehot(drive_in.x_sink_select) && $onehot(drive_in.y_sink_select);
endmodule

// file: testbench/csds_core_bench.sv
// Purpose: self-checking bench for the drive select core
// Assumes: clock enable held high; strap block 0 unless a test moves it
// Notes: inputs change 10 ns after each rising edge

`timescale 1ns/1ps

module csds_core_bench;
  import csds_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1;
  logic power_fail_low_in = 1'b1, bus_reset_low_in = 1'b1;
  logic master_sync_in = 1'b0, read_pause_in = 1'b0;
  logic [CSDS_BLK_W-1:0] block_strap_in = '0;
  logic [CSDS_ADDR_W-1:0] address_in = '0;
  logic address_match_out, busy_out, read_timing_pulse_out, write_timing_pulse_out;
  logic [7:0] drive_group_a_out, drive_group_c_out;
  logic [15:0] x_sink_select_out, y_sink_select_out;
  logic x_read_return_out, y_read_return_out, x_write_return_out, y_write_return_out;
  logic source_one_enable_out, source_two_enable_out;
  csds_drive_type drv;
  logic [6:0] x_line, y_line;
  logic sel_ok;
  int n_fail = 0, num_checks = 0;

  // ****************************************
  // clock, design and stack model
  // ****************************************
  always #50 clk_in = ~clk_in;
  csds_core csds_core_i (.*);
  assign drv = {drive_group_a_out, drive_group_c_out, x_sink_select_out, y_sink_select_out,
    x_read_return_out, y_read_return_out, x_write_return_out, y_write_return_out,
    source_one_enable_out, source_two_enable_out};
  csds_stack_model csds_stack_model_i (.drive_in(drv), .x_line_out(x_line),
    .y_line_out(y_line), .sel_ok_out(sel_ok));

  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clk_in);
      #10;
    end
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // raise the cycle request and wait for the first half to show
  task automatic start(input logic [17:0] a, input logic p);
    int n;
    address_in = a;
    read_pause_in = p;
    master_sync_in = 1'b1;
    n = 0;
    while (!(read_timing_pulse_out | write_timing_pulse_out) && n < 20) begin
      tick();
      n++;
    end
    chk(n < 20, 1'b1);
  endtask
  // one whole cycle; rd and wr say which halves are expected
  task automatic cycle(input logic [17:0] a, input logic p, rd, wr);
    int n;
    start(a, p);
    if (rd) begin
      chk(x_line, {a[13:10], a[3:1]});
      chk(y_line, {a[14], a[9:7], a[6:4]});
      chk({sel_ok, drv[5:0]}, 7'h73);
      n = 0;
      while (read_timing_pulse_out && n < 9) begin
        tick();
        n++;
      end
      chk(n, 3);
    end
    if (wr) begin
      chk(x_line, {a[13:10], a[3:1]});
      chk(y_line, {a[14], a[9:7], a[6:4]});
      chk({sel_ok, drv[5:0]}, 7'h4F);
      n = 0;
      while (write_timing_pulse_out && n < 9) begin
        tick();
        n++;
      end
      chk(n, 3);
    end
    chk(drv, CSDS_DRIVE_OFF);
    master_sync_in = 1'b0;
    tick(2);
    chk(busy_out, 1'b0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // every drive code in both fields, every sink code
  task automatic sc_decode();
    for (int i = 0; i < 16; i++)
      cycle({3'h0, i[3], 4'(i), 3'(~i), 3'(i + 1), 3'(i ^ 5), 1'b0}, 1'b0, 1'b1, 1'b1);
  endtask
  // read pause gives a read-only cycle, then a write-only one
  task automatic sc_pause();
    cycle(18'h05A5A, 1'b1, 1'b1, 1'b0);
    cycle(18'h05A5A, 1'b0, 1'b0, 1'b1);
  endtask
  // wrong strap, then power bad: requests ignored
  task automatic sc_refuse();
    block_strap_in = 3'h5;
    tick(4);
    chk(address_match_out, 1'b0);
    master_sync_in = 1'b1;
    tick(12);
    chk(busy_out, 1'b0);
    master_sync_in = 1'b0;
    block_strap_in = 3'h0;
    power_fail_low_in = 1'b0;
    tick(4);
    chk(address_match_out, 1'b0);
    master_sync_in = 1'b1;
    tick(12);
    chk(busy_out, 1'b0);
    master_sync_in = 1'b0;
    power_fail_low_in = 1'b1;
    tick(4);
    chk(address_match_out, 1'b1);
  endtask
  // power drops mid-cycle: returns off, write half still runs
  task automatic sc_midfail();
    start(18'h01234, 1'b0);
    power_fail_low_in = 1'b0;
    tick(4);
    chk({write_timing_pulse_out, drv[5:0]}, 7'h43);
    master_sync_in = 1'b0;
    tick(6);
    power_fail_low_in = 1'b1;
    tick(4);
  endtask
  // bus reset mid-cycle clears everything, then a clean cycle follows
  task automatic sc_init();
    start(18'h02345, 1'b0);
    bus_reset_low_in = 1'b0;
    tick(4);
    chk({busy_out, read_timing_pulse_out, write_timing_pulse_out, drv}, '0);
    master_sync_in = 1'b0;
    bus_reset_low_in = 1'b1;
    tick(4);
    cycle(18'h00777, 1'b0, 1'b1, 1'b1);
  endtask

  initial begin
    tick(4);
    rst_in = 1'b0;
    tick(4);
    chk(drv, CSDS_DRIVE_OFF);
    sc_decode();
    sc_pause();
    sc_refuse();
    sc_midfail();
    sc_init();
    report_and_stop();
  end
  // run needs about 300 cycles; 5000 means a hang
  initial begin
    #500000;
    n_fail++;
    report_and_stop();
  end
endmodule
